//--- pkg/alarm_repeat_defs.svh
`ifndef ALARM_REPEAT_DEFS_SVH
`define ALARM_REPEAT_DEFS_SVH

// register byte offsets
`define OFS_ALARM_CONTROL    8'h00
`define OFS_SECONDS          8'h04
`define OFS_CALENDAR_CONTROL 8'h08
`define OFS_CALENDAR_TRIM    8'h0c
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_CLEAR        8'h14
`define OFS_IRQ_ENABLE       8'h18
`define OFS_UNIT_STATUS      8'h1c

// alarm_control fields
`define BIT_ALARM_ENABLE     0
`define BIT_ENDLESS_REPEAT   1
`define LSB_REPEAT_COUNT     8

// status and enable fields
`define BIT_IRQ_ALARM        0
`define BIT_IRQ_FINAL        1
`define IRQ_BITS             2

// calendar_control fields
`define BIT_CLOCK_ON         0

// reset values and endless wrap value
`define RST_REPEAT_COUNT     8'h00
`define RST_CAL_CONTROL      8'h01
`define RST_CAL_TRIM         8'h00
`define RST_SECONDS          8'h00
`define RST_IRQ_ENABLE       2'h0
`define REPEAT_WRAP          8'hff

// timebase
`define CLOCK_PERIOD_NS      10
`define TIMEBASE_PERIOD_NS   1000000000
`define TIMEBASE_CYCLES      (`TIMEBASE_PERIOD_NS / `CLOCK_PERIOD_NS)

`endif

//--- pkg/alarm_repeat_pkg.sv
package alarm_repeat_pkg;

  typedef enum logic {
    BUS_IDLE,
    BUS_WRITE
  } bus_phase_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } pulse_state_t;

  typedef struct packed {
    logic        tick;
    logic        alarm_event;
  } timebase_t;

  typedef struct packed {
    logic [7:0] repeat_count;
    logic       endless;
    logic       enable;
  } alarm_ctrl_t;

  typedef struct packed {
    bus_phase_t phase;
    logic [7:0] addr;
  } bus_state_t;

  typedef struct packed {
    logic level;
  } toggle_state_t;

endpackage

//--- logic/alarm_pulse_toggle.sv
`timescale 1ns/100ps
module alarm_pulse_toggle (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire alarm_repeat_pkg::timebase_t tb,
  output logic                           pulse
);
  import alarm_repeat_pkg::*;

  toggle_state_t s;
  toggle_state_t next_s;

  // toggles only on a qualified event, which itself rides a timebase tick
  always_comb begin
    next_s = s;
    if (tb.tick && tb.alarm_event) begin
      next_s.level = ~s.level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.level;

endmodule

//--- logic/calendar_alarm_repeat_unit.sv
`timescale 1ns/100ps
`include "alarm_repeat_defs.svh"
// Notes on behaviour
// - count zero, no endless: single alarm only
// - eight-bit count, FFh gives 255 repeats
// - each alarm decrements count by one
// - at zero one more alarm issues
// - then hardware clears alarm enable
// - endless: wrap zero to FFh, stay enabled
// - each alarm sets flag, raises interrupt
// - pulse output toggles once per alarm
// - pulse synchronous to calendar timebase
// - runs through sleep/idle, alarm wakes cpu
// - calendar regs reset only by power-on/brownout
// - prescaler cleared only by seconds write or power-on/brownout
module calendar_alarm_repeat_unit #(
  parameter int TICK_CYCLES    = `TIMEBASE_CYCLES,
  parameter int PRESCALE_WIDTH = 27
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        device_reset,
  input  wire logic        alarm_match,
  output logic             irq,
  output logic             cpu_wake,
  output logic             alarm_pulse
);
  import alarm_repeat_pkg::*;

  typedef struct packed {
    bus_state_t                bus;
    logic [31:0]               rdata;
    alarm_ctrl_t               ctrl;
    logic [7:0]                seconds;
    logic [7:0]                cal_control;
    logic [7:0]                cal_trim;
    logic [`IRQ_BITS-1:0]      status;
    logic [`IRQ_BITS-1:0]      irq_en;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic                      wake;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;
  timebase_t   tb;

  logic                 addr_phase;
  logic                 wr_now;
  logic [7:0]           wr_addr;
  logic                 ctrl_wr;
  logic                 sec_wr;
  logic                 final_alarm;
  logic [`IRQ_BITS-1:0] set_bits;
  logic [`IRQ_BITS-1:0] clr_bits;

  localparam logic [PRESCALE_WIDTH-1:0] TICK_LAST =
    PRESCALE_WIDTH'(TICK_CYCLES - 1);

  function automatic logic [31:0] read_mux(input unit_state_t r, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      `OFS_ALARM_CONTROL: begin
        d[`BIT_ALARM_ENABLE]              = r.ctrl.enable;
        d[`BIT_ENDLESS_REPEAT]            = r.ctrl.endless;
        d[`LSB_REPEAT_COUNT +: 8]         = r.ctrl.repeat_count;
      end
      `OFS_SECONDS:          d[7:0]       = r.seconds;
      `OFS_CALENDAR_CONTROL: d[7:0]       = r.cal_control;
      `OFS_CALENDAR_TRIM:    d[7:0]       = r.cal_trim;
      `OFS_IRQ_STATUS:       d[`IRQ_BITS-1:0] = r.status;
      `OFS_IRQ_ENABLE:       d[`IRQ_BITS-1:0] = r.irq_en;
      `OFS_UNIT_STATUS:      d[0]         = alarm_pulse;
      default:               d            = 32'h0;
    endcase
    return d;
  endfunction

  // ahb-lite: zero wait states, always okay
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_now     = (s.bus.phase == BUS_WRITE);
  assign wr_addr    = s.bus.addr;
  assign ctrl_wr    = wr_now && (wr_addr == `OFS_ALARM_CONTROL);
  assign sec_wr     = wr_now && (wr_addr == `OFS_SECONDS);

  // timebase: matches only count on a tick, never on raw hclk
  assign tb.tick        = s.cal_control[`BIT_CLOCK_ON] && (s.prescale == TICK_LAST);
  assign tb.alarm_event = tb.tick && alarm_match && s.ctrl.enable;
  assign final_alarm    = tb.alarm_event && (s.ctrl.repeat_count == 8'h00) && !s.ctrl.endless;

  always_comb begin
    next_s   = s;
    set_bits = '0;
    clr_bits = '0;

    // bus phase tracking
    case (s.bus.phase)
      BUS_IDLE,
      BUS_WRITE: begin
        if (addr_phase && hwrite) begin
          next_s.bus.phase = BUS_WRITE;
          next_s.bus.addr  = haddr[7:0];
        end else begin
          next_s.bus.phase = BUS_IDLE;
          next_s.bus.addr  = s.bus.addr;
        end
      end
      default: begin
        next_s.bus.phase = BUS_IDLE;
      end
    endcase

    // prescaler is cleared by a seconds write or hresetn; device_reset does not reach it
    if (sec_wr) begin
      next_s.prescale = '0;
    end else if (s.cal_control[`BIT_CLOCK_ON]) begin
      if (s.prescale == TICK_LAST) begin
        next_s.prescale = '0;
      end else begin
        next_s.prescale = s.prescale + 1'b1;
      end
    end

    // repeat sequencing; ignored entirely while disabled
    if (tb.alarm_event) begin
      if (s.ctrl.repeat_count != 8'h00) begin
        next_s.ctrl.repeat_count = s.ctrl.repeat_count - 8'h01;
      end else if (s.ctrl.endless) begin
        next_s.ctrl.repeat_count = `REPEAT_WRAP;
      end else begin
        next_s.ctrl.enable = 1'b0;
      end
      set_bits[`BIT_IRQ_ALARM] = 1'b1;
    end
    set_bits[`BIT_IRQ_FINAL] = final_alarm;

    // wake runs regardless of any sleep or idle state
    next_s.wake = tb.alarm_event;

    // register writes; a software control write overrides the auto clear
    if (wr_now) begin
      case (wr_addr)
        `OFS_ALARM_CONTROL: begin
          next_s.ctrl.enable       = hwdata[`BIT_ALARM_ENABLE];
          next_s.ctrl.endless      = hwdata[`BIT_ENDLESS_REPEAT];
          next_s.ctrl.repeat_count = hwdata[`LSB_REPEAT_COUNT +: 8];
        end
        `OFS_SECONDS:          next_s.seconds     = hwdata[7:0];
        `OFS_CALENDAR_CONTROL: next_s.cal_control = hwdata[7:0];
        `OFS_CALENDAR_TRIM:    next_s.cal_trim    = hwdata[7:0];
        `OFS_IRQ_CLEAR:        clr_bits           = hwdata[`IRQ_BITS-1:0];
        `OFS_IRQ_ENABLE:       next_s.irq_en      = hwdata[`IRQ_BITS-1:0];
        default: begin
          next_s.seconds = s.seconds;
        end
      endcase
    end

    // interrupt enables belong to the core, so other device resets clear them
    if (device_reset) begin
      next_s.irq_en = `RST_IRQ_ENABLE;
    end

    // sticky status: a set in the clearing cycle survives
    next_s.status = (s.status & ~clr_bits) | set_bits;

    // read data from the post-write state so read-after-write needs no stall
    if (addr_phase && !hwrite) begin
      next_s.rdata = read_mux(next_s, haddr[7:0]);
    end
  end

  // hresetn stands for power-on / brownout only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.bus.phase         <= BUS_IDLE;
      s.bus.addr          <= 8'h00;
      s.rdata             <= 32'h0;
      s.ctrl.repeat_count <= `RST_REPEAT_COUNT;
      s.ctrl.endless      <= 1'b0;
      s.ctrl.enable       <= 1'b0;
      s.seconds           <= `RST_SECONDS;
      s.cal_control       <= `RST_CAL_CONTROL;
      s.cal_trim          <= `RST_CAL_TRIM;
      s.status            <= '0;
      s.irq_en            <= `RST_IRQ_ENABLE;
      s.prescale          <= '0;
      s.wake              <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  alarm_pulse_toggle u_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tb      (tb),
    .pulse   (alarm_pulse)
  );

  assign hrdata   = s.rdata;
  assign irq      = |(s.status & s.irq_en);
  assign cpu_wake = s.wake;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_counted_alarm;
    tb.alarm_event && (s.ctrl.repeat_count != 8'h00) && !ctrl_wr;
  endsequence

  sequence s_last_alarm;
    tb.alarm_event && (s.ctrl.repeat_count == 8'h00) && !s.ctrl.endless && !ctrl_wr;
  endsequence

  sequence s_wrap_alarm;
    tb.alarm_event && (s.ctrl.repeat_count == 8'h00) && s.ctrl.endless && !ctrl_wr;
  endsequence

  a_count_decrement: assert property (
    s_counted_alarm |=> s.ctrl.repeat_count == $past(s.ctrl.repeat_count) - 8'h01)
    else $error("repeat count did not drop by one");

  a_last_disables: assert property (
    s_last_alarm |=> !s.ctrl.enable)
    else $error("enable not cleared after final alarm");

  a_single_stop: assert property (
    s_last_alarm ##1 !ctrl_wr |-> !tb.alarm_event)
    else $error("alarm repeated after final one");

  a_zero_still_fires: assert property (
    (s.ctrl.repeat_count == 8'h00) && s.ctrl.enable && tb.tick && alarm_match
    |-> tb.alarm_event ##1 s.status[`BIT_IRQ_ALARM])
    else $error("no alarm issued at count zero");

  a_endless_wrap: assert property (
    s_wrap_alarm |=> (s.ctrl.repeat_count == `REPEAT_WRAP) && s.ctrl.enable)
    else $error("endless repeat did not wrap");

  a_flag_irq: assert property (
    tb.alarm_event && s.irq_en[`BIT_IRQ_ALARM] && !device_reset |=> s.status[`BIT_IRQ_ALARM] && irq)
    else $error("alarm did not set flag and interrupt");

  a_pulse_toggle: assert property (
    tb.alarm_event |=> alarm_pulse != $past(alarm_pulse))
    else $error("pulse did not toggle on alarm");

  a_pulse_on_tick: assert property (
    $changed(alarm_pulse) |-> $past(tb.tick))
    else $error("pulse moved off the timebase tick");

  a_disabled_quiet: assert property (
    !s.ctrl.enable && !ctrl_wr |=> $stable(s.ctrl.repeat_count) && $stable(alarm_pulse))
    else $error("disabled alarm changed state");

  a_wake_follows: assert property (
    tb.alarm_event |=> cpu_wake ##1 (!cpu_wake || $past(tb.alarm_event)))
    else $error("wake not raised by alarm");

  a_prescale_clear: assert property (
    sec_wr |=> s.prescale == '0)
    else $error("seconds write did not clear prescaler");

  a_prescale_kept: assert property (
    device_reset && !sec_wr && (s.prescale != TICK_LAST) && s.cal_control[`BIT_CLOCK_ON]
    |=> s.prescale == $past(s.prescale) + 1'b1)
    else $error("device reset disturbed prescaler");

  a_cal_kept: assert property (
    device_reset && !wr_now |=> $stable(s.cal_control) && $stable(s.cal_trim))
    else $error("device reset touched calendar registers");

endmodule

//--- verification/calendar_alarm_repeat_unit_bench.sv
`timescale 1ns/100ps
`include "alarm_repeat_defs.svh"
module calendar_alarm_repeat_unit_bench;
  import alarm_repeat_pkg::*;
  localparam int TICK = 8;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        device_reset;
  logic        alarm_match;
  logic        irq;
  logic        cpu_wake;
  logic        alarm_pulse;
  logic [31:0] rd;
  int          error_cnt;
  int          check_count;
  int          ev_count;
  int          m_cnt;
  int          m_en;
  int          m_end;
  int          m_pulse;
  int          m_st;
  int          d1;
  int          d2;
  int          n;

  calendar_alarm_repeat_unit #(.TICK_CYCLES(TICK)) calendar_alarm_repeat_unit_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .device_reset(device_reset),
    .alarm_match(alarm_match), .irq(irq), .cpu_wake(cpu_wake), .alarm_pulse(alarm_pulse)
  );
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // no wait limit here: only the watchdog ends a stuck transfer
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk(32'(hresp), 32'h0);
  endtask

  function automatic logic [31:0] ctl_exp();
    return {16'h0, 8'(m_cnt), 6'h0, 1'(m_end), 1'(m_en)};
  endfunction

  // model follows each event; cpu_wake marks the cycle after it
  always @(posedge hclk) begin
    if (cpu_wake === 1'b1) begin
      ev_count++;
      m_st |= 1;
      if (m_cnt == 0 && m_end == 0) begin
        m_en = 0;
        m_st |= 2;
      end
      else m_cnt = (m_cnt == 0) ? 255 : m_cnt - 1;
      m_pulse ^= 1;
      chk(alarm_pulse, 32'(m_pulse));
    end
  end

  task wait_ev(input int target);
    int k;
    k = 0;
    while (ev_count < target && k < 4 * TICK) begin
      @(negedge hclk);
      k++;
    end
    // hand back on a rising edge so inputs move there
    @(posedge hclk);
    chk(ev_count, target);
  endtask

  task run(input logic [7:0] cnt, input logic endl, input int evs);
    int s;
    bus(`OFS_IRQ_CLEAR, 1'b1, 32'h3);
    m_st = 0;
    bus(`OFS_ALARM_CONTROL, 1'b1, {16'h0, cnt, 6'h0, endl, 1'b0});
    bus(`OFS_ALARM_CONTROL, 1'b1, {16'h0, cnt, 6'h0, endl, 1'b1});
    m_cnt = cnt;
    m_end = endl;
    m_en = 1;
    s = ev_count;
    alarm_match <= 1'b1;
    for (int i = 1; i <= evs; i++) begin
      wait_ev(s + i);
      if (endl && i == evs) alarm_match <= 1'b0;
      rd_chk(`OFS_ALARM_CONTROL, ctl_exp());
      chk(irq, 1);
    end
    if (endl) begin
      bus(`OFS_ALARM_CONTROL, 1'b1, 32'h0);
      m_en = 0;
      m_end = 0;
      m_cnt = 0;
      alarm_match <= 1'b1;
    end
    repeat (3 * TICK) @(posedge hclk);
    chk(ev_count, s + evs);
    rd_chk(`OFS_IRQ_STATUS, 32'(m_st));
    rd_chk(`OFS_UNIT_STATUS, 32'(m_pulse));
    alarm_match <= 1'b0;
    $display("test repeat %0d endless %0d done", cnt, endl);
  endtask

  task measure(output int d, input logic pulse_rst);
    int s;
    s = ev_count;
    d = 0;
    bus(`OFS_SECONDS, 1'b1, 32'h0);
    alarm_match <= 1'b1;
    device_reset <= pulse_rst;
    @(posedge hclk);
    device_reset <= 1'b0;
    while (ev_count == s && d < 4 * TICK) begin
      @(negedge hclk);
      d++;
    end
    @(posedge hclk);
    alarm_match <= 1'b0;
    chk(ev_count, s + 1);
  endtask

  initial begin
    #(20000 * 10);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    device_reset = 1'b0;
    alarm_match = 1'b0;
    void'($urandom(22282));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`OFS_ALARM_CONTROL, 32'h0);
    rd_chk(`OFS_CALENDAR_CONTROL, 32'h1);
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    rd_chk(8'h20, 32'h0);
    chk(alarm_pulse, 0);
    $display("test reset done");
    bus(`OFS_IRQ_ENABLE, 1'b1, 32'h3);
    run(8'h00, 1'b0, 1);
    n = 1 + $urandom % 6;
    run(8'(n), 1'b0, n + 1);
    run(8'hff, 1'b0, 256);
    run(8'h01, 1'b1, 4);
    bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0);
    // irq is combinational of the new enable, settled only after the edge
    @(negedge hclk);
    chk(irq, 0);
    bus(`OFS_IRQ_CLEAR, 1'b1, 32'h3);
    m_st = 0;
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    $display("test irq mask done");
    n = $urandom % 256;
    bus(`OFS_CALENDAR_TRIM, 1'b1, 32'(n));
    bus(`OFS_IRQ_ENABLE, 1'b1, 32'h3);
    bus(`OFS_ALARM_CONTROL, 1'b1, 32'h0502);
    bus(`OFS_ALARM_CONTROL, 1'b1, 32'h0503);
    m_cnt = 5;
    m_end = 1;
    m_en = 1;
    // clock off: no tick, so a standing match stays quiet
    bus(`OFS_CALENDAR_CONTROL, 1'b1, 32'h0);
    d1 = ev_count;
    alarm_match <= 1'b1;
    repeat (3 * TICK) @(posedge hclk);
    alarm_match <= 1'b0;
    chk(ev_count, d1);
    bus(`OFS_CALENDAR_CONTROL, 1'b1, 32'h1);
    $display("test clock off done");
    measure(d1, 1'b0);
    repeat (3) @(posedge hclk);
    measure(d2, 1'b1);
    chk(d2, d1);
    rd_chk(`OFS_IRQ_ENABLE, 32'h0);
    rd_chk(`OFS_CALENDAR_TRIM, 32'(n));
    rd_chk(`OFS_ALARM_CONTROL, ctl_exp());
    $display("test prescaler and device reset done");
    report_and_stop();
  end
endmodule
